/* File: src/ewsg_pkg.sv */
// constants for the external wait-state generator and program page logic
// assumes a 16-bit memory-mapped register port from the core
`default_nettype none
package ewsg_pkg;
  localparam logic [15:0] EWSG_ADDR_PAGE = 16'h001e;
  localparam logic [15:0] EWSG_ADDR_COUNT = 16'h0028;
  localparam logic [15:0] EWSG_ADDR_CONTROL = 16'h002b;
  localparam logic [15:0] EWSG_COUNT_RESET = 16'h7fff;
  localparam logic [15:0] EWSG_PAGE_RESET = 16'h0000;
  localparam logic [15:0] EWSG_CONTROL_RESET = 16'h0000;
  localparam int EWSG_XPA_BIT = 15;
  localparam int EWSG_IO_LSB = 12;
  localparam int EWSG_DHI_LSB = 9;
  localparam int EWSG_DLO_LSB = 6;
  localparam int EWSG_PHI_LSB = 3;
  localparam int EWSG_PLO_LSB = 0;
  localparam int EWSG_MULT_BIT = 0;
  localparam int EWSG_PAGE_W = 4;
  localparam int EWSG_PADDR_W = 20;
  localparam logic [1:0] EWSG_SPACE_PROG = 2'h0;
  localparam logic [1:0] EWSG_SPACE_DATA = 2'h1;
  localparam logic [1:0] EWSG_SPACE_IO = 2'h2;
  localparam logic [1:0] EWSG_PAGE_KEEP = 2'h0;
  localparam logic [1:0] EWSG_PAGE_LOAD = 2'h1;
  localparam logic [3:0] EWSG_MAX_WAIT = 4'he;
  // low 16K words of a page: address bits 15:14 both zero
  localparam logic [1:0] EWSG_RAM_OVERLAY_TOP = 2'h0;
  typedef enum logic [1:0] {
    EWSG_IDLE = 2'b00,
    EWSG_WAIT = 2'b01,
    EWSG_READY = 2'b10,
    EWSG_DONE = 2'b11
  } ewsg_state_t;
endpackage
`default_nettype wire

/* File: src/ewsg_count_sel.sv */
// selects the base wait count of one access from the count register
// assumes combinational use inside the wait-state generator
`timescale 1ns/1ps
`default_nettype none
module ewsg_count_sel
  import ewsg_pkg::*;
(
  input wire logic [15:0] counts, // wait_count_reg contents
  input wire logic [1:0] space, // access space
  input wire logic [15:0] addr, // low address bits
  output logic [2:0] base // selected base count
);
  always_comb
  begin
    base = counts[EWSG_PLO_LSB +: 3];
    unique case (space)
      EWSG_SPACE_IO: base = counts[EWSG_IO_LSB +: 3];
      EWSG_SPACE_DATA:
      begin
        if (addr[15])
          base = counts[EWSG_DHI_LSB +: 3];
        else
          base = counts[EWSG_DLO_LSB +: 3];
      end
      EWSG_SPACE_PROG:
      begin
        // extended select makes the low field cover the whole space
        if (!counts[EWSG_XPA_BIT] && addr[15])
          base = counts[EWSG_PHI_LSB +: 3];
        else
          base = counts[EWSG_PLO_LSB +: 3];
      end
      default: base = counts[EWSG_PLO_LSB +: 3];
    endcase
  end
endmodule
`default_nettype wire

/* File: src/ewsg_top.sv */
// external wait-state generator with program page register
// assumes the core presents one external access at a time and holds it
// until done; ext_ready comes from the bus and is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
// Operation
// - external cycles stretch by programmed wait states, fourteen at most
// - counter clock gated off when all ranges program zero waits
// - all count fields reset to seven waits
// - bits 14:12 set I/O space base count
// - bits 11:9 set upper data half base count
// - bits 8:6 set lower data half base count
// - bits 5:3 set upper program half count unless extended select
// - bits 2:0 set lower program half, or all program with extended select
// - multiplier bit doubles base counts, giving at most fourteen
// - control bits 15:1 read zero and ignore writes
// - program page register at 001Eh, cleared by reset
// - twenty program address lines, sixteen pages of 64K words
// - far branch, call and return and stores to the page register change the page
// - accumulator program reads and writes use full twenty-bit address
// - overlay maps low 16K of every page on-chip; page 0 low 16K is on-chip even without it
module ewsg_top
  import ewsg_pkg::*;
(
  input wire logic clk, // machine clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [15:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // register write data
  output logic [15:0] reg_rdata, // register read data
  input wire logic acc_req, // external access request
  input wire logic [1:0] acc_space, // program, data or I/O
  input wire logic [15:0] acc_addr, // 16-bit access address
  input wire logic acc_long, // use full 20-bit accumulator address
  input wire logic [19:0] acc_long_addr, // accumulator address
  input wire logic ram_overlay, // overlay mode bit
  input wire logic ext_ready, // hardware ready from the bus
  input wire logic [1:0] page_op, // keep or load page
  input wire logic [3:0] page_new, // page from far instruction
  output logic acc_done, // access completes, one cycle
  output logic acc_internal, // access went to on-chip overlay
  output logic [19:0] prog_addr, // program address lines
  output logic wait_clk_en, // counter clock enable
  output logic [3:0] wait_count // waits left in current access
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] wait_count_reg;
  logic [15:0] wait_control_reg;
  logic [15:0] program_page_reg;
  logic [2:0] base;
  logic [3:0] total;
  logic [19:0] next_prog_addr;
  logic overlay_hit;
  ewsg_state_t state;
  logic wr_count;
  logic wr_control;
  logic wr_page;
  logic page_load;
  logic rd_count;
  logic rd_control;
  logic rd_page;
  logic multiplier;
  logic [3:0] page_cur;
  logic [2:0] io_field;
  logic [2:0] dhi_field;
  logic [2:0] dlo_field;
  logic [2:0] phi_field;
  logic [2:0] plo_field;
  logic ext_range;
  logic field_any;
  logic low_region;
  logic page_zero;
  logic take;
  logic wait_last;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wr_count = reg_wr && reg_addr == EWSG_ADDR_COUNT;
  assign wr_control = reg_wr && reg_addr == EWSG_ADDR_CONTROL;
  assign wr_page = reg_wr && reg_addr == EWSG_ADDR_PAGE;
  assign rd_count = reg_rd && reg_addr == EWSG_ADDR_COUNT;
  assign rd_control = reg_rd && reg_addr == EWSG_ADDR_CONTROL;
  assign rd_page = reg_rd && reg_addr == EWSG_ADDR_PAGE;
  assign page_load = page_op == EWSG_PAGE_LOAD;

  // ----------------------------------------------------------------
  // wait-state count register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wait_count_reg <= EWSG_COUNT_RESET;
    else if (wr_count)
      wait_count_reg <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // count fields
  // ----------------------------------------------------------------
  assign io_field = wait_count_reg[EWSG_IO_LSB +: 3];
  assign dhi_field = wait_count_reg[EWSG_DHI_LSB +: 3];
  assign dlo_field = wait_count_reg[EWSG_DLO_LSB +: 3];
  assign phi_field = wait_count_reg[EWSG_PHI_LSB +: 3];
  assign plo_field = wait_count_reg[EWSG_PLO_LSB +: 3];
  assign ext_range = wait_count_reg[EWSG_XPA_BIT];

  // upper program field is dead under the extended select, so it
  // must not keep the counter clock running
  assign field_any = |io_field || |dhi_field || |dlo_field ||
    (!ext_range && |phi_field) || |plo_field;

  // ----------------------------------------------------------------
  // wait-state control register
  // ----------------------------------------------------------------
  // only the multiplier is stored; reserved bits cost no flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wait_control_reg <= EWSG_CONTROL_RESET;
    else if (wr_control)
      wait_control_reg <= {15'h0000, reg_wdata[EWSG_MULT_BIT]};
  end

  assign multiplier = wait_control_reg[EWSG_MULT_BIT];

  // ----------------------------------------------------------------
  // program page register
  // ----------------------------------------------------------------
  // a far instruction wins over a same-cycle store to the page
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      program_page_reg <= EWSG_PAGE_RESET;
    else if (page_load)
      program_page_reg <= {12'h000, page_new};
    else if (wr_page)
      program_page_reg <= {12'h000, reg_wdata[EWSG_PAGE_W-1:0]};
  end

  assign page_cur = program_page_reg[EWSG_PAGE_W-1:0];

  // ----------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------
  // read data holds until the next read, so slow pollers lose nothing
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 16'h0000;
    else if (rd_count)
      reg_rdata <= wait_count_reg;
    else if (rd_control)
      reg_rdata <= wait_control_reg;
    else if (rd_page)
      reg_rdata <= program_page_reg;
    else if (reg_rd)
      reg_rdata <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  ewsg_count_sel u_sel (
    .counts(wait_count_reg),
    .space(acc_space),
    .addr(acc_addr),
    .base(base)
  );

  // doubling keeps the total within 14
  always_comb
  begin
    if (multiplier)
      total = {base, 1'b0};
    else
      total = {1'b0, base};
  end

  // ----------------------------------------------------------------
  // program address and overlay
  // ----------------------------------------------------------------
  always_comb
  begin
    if (acc_long)
      next_prog_addr = acc_long_addr;
    else
      next_prog_addr = {page_cur, acc_addr};
  end

  // page 0 low region is always internal; other pages only under overlay
  assign low_region = next_prog_addr[15:14] == EWSG_RAM_OVERLAY_TOP;
  assign page_zero = next_prog_addr[19:16] == 4'h0;
  assign overlay_hit = acc_space == EWSG_SPACE_PROG && low_region &&
    (ram_overlay || page_zero);

  // ----------------------------------------------------------------
  // wait sequencing
  // ----------------------------------------------------------------
  assign take = state == EWSG_IDLE && acc_req;
  assign wait_last = wait_count <= 4'h1;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wait_clk_en <= 1'b0;
    else
      wait_clk_en <= field_any;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= EWSG_IDLE;
    else
    begin
      unique case (state)
        EWSG_IDLE:
        begin
          if (acc_req)
          begin
            if (overlay_hit)
              state <= EWSG_DONE;
            else if (total == 4'h0 || !wait_clk_en)
              state <= EWSG_READY;
            else
              state <= EWSG_WAIT;
          end
        end
        EWSG_WAIT:
        begin
          if (wait_last)
            state <= EWSG_READY;
        end
        EWSG_READY:
        begin
          // slow devices stretch beyond fourteen through ext_ready
          if (ext_ready)
            state <= EWSG_DONE;
        end
        EWSG_DONE:
        begin
          // one dead cycle lets the core drop its request
          state <= EWSG_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wait counter
  // ----------------------------------------------------------------
  // count gated off unless some live field is nonzero; idle value is zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wait_count <= 4'h0;
    else if (take && !overlay_hit && wait_clk_en)
      wait_count <= total;
    else if (state == EWSG_WAIT && wait_last)
      wait_count <= 4'h0;
    else if (state == EWSG_WAIT)
      wait_count <= wait_count - 4'h1;
  end

  // ----------------------------------------------------------------
  // completion
  // ----------------------------------------------------------------
  // done is a single pulse; the core drops its request after it
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      acc_done <= 1'b0;
    else
      acc_done <= (take && overlay_hit) ||
        (state == EWSG_READY && ext_ready);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      acc_internal <= 1'b0;
    else if (take)
      acc_internal <= overlay_hit;
  end

  // address lines keep the last program address between accesses
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prog_addr <= 20'h00000;
    else if (take && acc_space == EWSG_SPACE_PROG)
      prog_addr <= next_prog_addr;
  end
endmodule
`default_nettype wire

/* File: sim/ewsg_bus_dev.sv */
// external memory or I/O device model answering on the ready line
// assumes acc_req held by the core from take until done
`timescale 1ns/1ps
`default_nettype none
module ewsg_bus_dev (
  input wire logic clk, // machine clock
  input wire logic arst_n, // reset, active low
  input wire logic acc_req, // access request from the core
  input wire logic [3:0] stall, // extra cycles this device needs
  output logic ext_ready // ready back to the generator
);
  logic [3:0] hold;
  // reloads while idle, so a slow part holds off each access afresh
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      hold <= 4'h0;
    else if (!acc_req)
      hold <= stall;
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
  assign ext_ready = (hold == 4'h0);
endmodule
`default_nettype wire

/* File: sim/ewsg_props.sv */
// port checker for the wait-state generator
// assumes bound into ewsg_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ewsg_props
  import ewsg_pkg::*;
(
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_addr, // address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic [15:0] reg_rdata, // read data
  input wire logic ext_ready, // bus ready
  input wire logic [1:0] page_op, // page op
  input wire logic [3:0] page_new, // new page
  input wire logic acc_done, // done pulse
  input wire logic acc_internal, // overlay hit
  input wire logic wait_clk_en, // counter enable
  input wire logic [3:0] wait_count // waits left
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  done_pulse_a: assert property (acc_done |=> !acc_done)
    else $error("done held longer than a cycle");
  wait_max_a: assert property (wait_count <= EWSG_MAX_WAIT)
    else $error("wait count above fourteen");
  wait_dec_a: assert property (wait_count != 4'h0 |=>
    wait_count == $past(wait_count) - 4'h1) else $error("count stuck");
  gate_zero_a: assert property (!wait_clk_en |-> wait_count == 4'h0)
    else $error("counting while gated");
  done_ready_a: assert property (acc_done && !acc_internal |->
    $past(ext_ready)) else $error("done without ready");
  ctl_read_a: assert property (
    reg_rd && reg_addr == EWSG_ADDR_CONTROL |=> reg_rdata[15:1] == 15'h0000)
    else $error("reserved bits set");
  count_rw_a: assert property (reg_wr && !reg_rd && reg_addr ==
    EWSG_ADDR_COUNT ##1 reg_rd && !reg_wr && reg_addr == EWSG_ADDR_COUNT
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("count readback");
  page_load_a: assert property (
    page_op == EWSG_PAGE_LOAD ##1 reg_rd &&
    !reg_wr && reg_addr == EWSG_ADDR_PAGE && page_op != EWSG_PAGE_LOAD
    |=> reg_rdata == {12'h000, $past(page_new, 2)}) else $error("page");
endmodule
bind ewsg_top ewsg_props i_props (.clk(clk), .arst_n(arst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_ready(ext_ready),
  .page_op(page_op), .page_new(page_new), .acc_done(acc_done),
  .acc_internal(acc_internal), .wait_clk_en(wait_clk_en),
  .wait_count(wait_count));
`default_nettype wire

/* File: sim/external_wait_state_gen_tb.sv */
// self-checking bench for the wait-state generator
// assumes ewsg_top, the bus device model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module external_wait_state_gen_tb;
  import ewsg_pkg::*;
  logic clk, arst_n, reg_wr, reg_rd, acc_req, acc_long, ram_overlay, mult;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, acc_addr, cnt;
  logic [1:0] acc_space, page_op;
  logic [3:0] page_new, stall, page, pg, wait_count, wc;
  logic [19:0] acc_long_addr, prog_addr;
  logic acc_done, acc_internal, wait_clk_en, ext_ready, hit;
  int err_count, samples_checked, n, e, x;
  ewsg_top i_dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_space(acc_space),
    .acc_addr(acc_addr), .acc_long(acc_long), .acc_long_addr(acc_long_addr),
    .ram_overlay(ram_overlay), .ext_ready(ext_ready), .page_op(page_op),
    .page_new(page_new), .acc_done(acc_done), .acc_internal(acc_internal),
    .prog_addr(prog_addr), .wait_clk_en(wait_clk_en),
    .wait_count(wait_count));
  ewsg_bus_dev i_dev (.clk(clk), .arst_n(arst_n), .acc_req(acc_req),
    .stall(stall), .ext_ready(ext_ready));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(20'(reg_rdata), 20'(exp));
    @(negedge clk);
  endtask
  // write then read straight back on the next cycle
  task automatic wrd(input logic [15:0] a, d, exp);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    rd(a, exp);
  endtask
  function automatic int waits(input logic [15:0] c, input logic m,
      input logic [1:0] s, input logic [15:0] a);
    logic [2:0] b;
    if (s == EWSG_SPACE_IO)
      b = c[14:12];
    else if (s == EWSG_SPACE_DATA)
      b = a[15] ? c[11:9] : c[8:6];
    else
      b = (!c[15] && a[15]) ? c[5:3] : c[2:0];
    return m ? 2 * b : b;
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    {reg_wr, reg_rd, acc_req, acc_long, ram_overlay, reg_addr, reg_wdata,
      acc_addr, acc_space, page_op, page_new, acc_long_addr, stall} = '0;
    arst_n = 1'b0;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(18264));
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    rd(EWSG_ADDR_COUNT, EWSG_COUNT_RESET);
    rd(EWSG_ADDR_CONTROL, EWSG_CONTROL_RESET);
    rd(EWSG_ADDR_PAGE, EWSG_PAGE_RESET);
    rd(16'h0029, 16'h0000);
    wrd(EWSG_ADDR_COUNT, 16'h8038, 16'h8038);
    chk(20'(wait_clk_en), 20'h0);
    wrd(EWSG_ADDR_COUNT, 16'h0040, 16'h0040);
    chk(20'(wait_clk_en), 20'h1);
    // a reset in mid-run must restore the count and the page
    page_op = EWSG_PAGE_LOAD;
    page_new = 4'h9;
    @(negedge clk);
    page_op = EWSG_PAGE_KEEP;
    arst_n = 1'b0;
    @(negedge clk);
    chk(20'(wait_clk_en), 20'h0);
    arst_n = 1'b1;
    @(negedge clk);
    rd(EWSG_ADDR_COUNT, EWSG_COUNT_RESET);
    rd(EWSG_ADDR_PAGE, EWSG_PAGE_RESET);
    chk(20'(wait_clk_en), 20'h1);
    for (int i = 0; i < 32; i++)
    begin
      // all-sevens half the time to reach the fourteen-wait ceiling
      cnt = i[0] ? 16'h7fff : 16'($urandom);
      mult = 1'($urandom);
      page = 4'($urandom);
      acc_space = 2'($urandom_range(2));
      acc_long = 1'($urandom);
      acc_long_addr = 20'($urandom);
      ram_overlay = 1'($urandom);
      stall = 4'($urandom_range(3));
      wrd(EWSG_ADDR_COUNT, cnt, cnt);
      wrd(EWSG_ADDR_CONTROL, {15'h7fff, mult}, {15'h0000, mult});
      page_op = EWSG_PAGE_LOAD;
      page_new = page;
      @(negedge clk);
      page_op = EWSG_PAGE_KEEP;
      rd(EWSG_ADDR_PAGE, {12'h000, page});
      acc_addr = acc_long ? acc_long_addr[15:0] : 16'($urandom);
      pg = acc_long ? acc_long_addr[19:16] : page;
      hit = acc_space == EWSG_SPACE_PROG && acc_addr[15:14] == 2'h0 &&
        (pg == 4'h0 || ram_overlay);
      e = waits(cnt, mult, acc_space, acc_addr);
      acc_req = 1'b1;
      n = 0;
      wc = 4'h0;
      do
      begin
        @(negedge clk);
        n++;
        if (n == 1)
          wc = wait_count;
      end while (!acc_done && n < 40);
      acc_req = 1'b0;
      if (n >= 40)
      begin
        err_count++;
        break;
      end
      // overlay hits finish at the take edge itself
      x = e + 2 > stall + 1 ? e + 2 : stall + 1;
      chk(20'(n), 20'(hit ? 1 : x));
      chk(20'(wc), 20'(hit ? 0 : e));
      chk(20'(acc_internal), 20'(hit));
      if (acc_space == EWSG_SPACE_PROG)
        chk(prog_addr, acc_long ? acc_long_addr : {page, acc_addr});
      @(negedge clk);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
